/* logic/phyec_defines.svh */
`ifndef PHYEC_DEFINES_SVH
`define PHYEC_DEFINES_SVH

`define PHYEC_ADDR_FALSE_CARRIER 5'h14
`define PHYEC_ADDR_RX_ERROR       5'h15
`define PHYEC_ADDR_PCS_CONFIG     5'h16

`define PHYEC_BIT_TRUE_QUIET      10
`define PHYEC_BIT_SD_OVERRIDE     9
`define PHYEC_BIT_SD_ALGO         8
`define PHYEC_BIT_DESC_EXTEND     7

`define PHYEC_RST_TRUE_QUIET      1'h0
`define PHYEC_RST_SD_OVERRIDE     1'h0
`define PHYEC_RST_SD_ALGO         1'h1
`define PHYEC_RST_DESC_EXTEND     1'h0

`define PHYEC_CLK_MHZ             50
`define PHYEC_DESC_STD_US         722
`define PHYEC_DESC_EXT_US         2000

`endif

/* logic/phyec_pkg.sv */
package phyec_pkg;

  typedef struct packed {
    logic true_quiet_transmit_enable;
    logic signal_detect_override;
    logic signal_detect_algorithm_select;
    logic descrambler_timeout_extend;
  } phyec_cfg_t;

  typedef struct packed {
    logic false_carrier;
    logic carrier_valid;
    logic invalid_symbol;
    logic collision;
  } phyec_rx_evt_t;

endpackage

/* logic/phyec_regs.sv */
`timescale 1ns/100ps
`include "phyec_defines.svh"

module phyec_regs
  import phyec_pkg::*;
#(
  parameter int unsigned CNT_W        = 8,
  parameter int unsigned TMO_W        = 17,
  parameter int unsigned DESC_STD_CYC = `PHYEC_DESC_STD_US * `PHYEC_CLK_MHZ,
  parameter int unsigned DESC_EXT_CYC = `PHYEC_DESC_EXT_US * `PHYEC_CLK_MHZ
)
(
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          nrst,
  // Management register port
  input  wire logic [4:0]    reg_addr,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  input  wire logic [15:0]   reg_wdata,
  output logic      [15:0]   reg_rdata,
  output logic               reg_rvalid,
  // Receive path events
  input  phyec_rx_evt_t      rx_evt,
  // PCS configuration
  output phyec_cfg_t         pcs_cfg,
  output logic [TMO_W-1:0]   desc_timeout_cycles
);

  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
  localparam int unsigned      N_TALLY = 2;
  localparam int unsigned      N_CFG   = 4;
  localparam int unsigned      T_FC    = 0;
  localparam int unsigned      T_RE    = 1;

  // Progress of one carrier event; the veto state absorbs everything after a collision
  typedef enum logic [1:0]
  {
    CAR_IDLE  = 2'b00,
    CAR_CLEAN = 2'b01,
    CAR_ERROR = 2'b10,
    CAR_VETO  = 2'b11
  } phyec_car_state_t;

  phyec_car_state_t       car_state_r;
  phyec_car_state_t       car_state_nxt;
  logic                   rx_err_inc;
  logic [N_TALLY-1:0]     tally_inc;
  logic [N_TALLY-1:0]     tally_clr;
  wire logic [CNT_W-1:0]  tally_q [N_TALLY];
  wire logic [N_CFG-1:0]  cfg_bits;
  logic [N_CFG-1:0]       cfg_rst;
  logic                   cfg_wr;
  logic [15:0]            reg_rdata_r;
  logic                   reg_rvalid_r;
  logic                   rd_fc;
  logic                   rd_re;
  logic                   rd_cfg;

  function automatic logic addr_hit(input logic [4:0] a, input logic [4:0] target);
    addr_hit = (a == target);
  endfunction

  // Clear first, then count, so an event on the read cycle survives
  function automatic logic [CNT_W-1:0] tally_next(input logic [CNT_W-1:0] cur,
                                                  input logic             inc,
                                                  input logic             clr);
    logic [CNT_W-1:0] base;
    base = clr ? '0 : cur;
    if (inc && base != CNT_MAX)
      tally_next = base + 1'b1;
    else
      tally_next = base;
  endfunction

  // Register bit that carries configuration flag idx, msb flag first
  function automatic int unsigned cfg_bit_pos(input int unsigned idx);
    if (idx == 3)
      cfg_bit_pos = `PHYEC_BIT_TRUE_QUIET;
    else if (idx == 2)
      cfg_bit_pos = `PHYEC_BIT_SD_OVERRIDE;
    else if (idx == 1)
      cfg_bit_pos = `PHYEC_BIT_SD_ALGO;
    else
      cfg_bit_pos = `PHYEC_BIT_DESC_EXTEND;
  endfunction

  function automatic logic [15:0] pad_tally(input logic [CNT_W-1:0] t);
    pad_tally = {{(16-CNT_W){1'b0}}, t};
  endfunction

  // Reserved and unimplemented bits stay zero
  function automatic logic [15:0] cfg_word(input logic [N_CFG-1:0] bits);
    logic [15:0] w;
    w = 16'h0000;
    for (int unsigned i = 0; i < N_CFG; i++)
      w[cfg_bit_pos(i)] = bits[i];
    cfg_word = w;
  endfunction

  // Address decode
  assign rd_fc  = reg_rd && addr_hit(reg_addr, `PHYEC_ADDR_FALSE_CARRIER);
  assign rd_re  = reg_rd && addr_hit(reg_addr, `PHYEC_ADDR_RX_ERROR);
  assign rd_cfg = reg_rd && addr_hit(reg_addr, `PHYEC_ADDR_PCS_CONFIG);
  assign cfg_wr = reg_wr && addr_hit(reg_addr, `PHYEC_ADDR_PCS_CONFIG);

  // Carrier tracking
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      car_state_r <= CAR_IDLE;
    else
      car_state_r <= car_state_nxt;
  end

  // Counted at carrier close so a late collision can still veto it
  always_comb
  begin
    car_state_nxt = car_state_r;
    rx_err_inc    = 1'b0;
    case (car_state_r)
      CAR_IDLE,
      CAR_CLEAN:
      begin
        if (!rx_evt.carrier_valid)
          car_state_nxt = CAR_IDLE;
        else if (rx_evt.collision)
          car_state_nxt = CAR_VETO;
        else if (rx_evt.invalid_symbol)
          car_state_nxt = CAR_ERROR;
        else
          car_state_nxt = CAR_CLEAN;
      end
      CAR_ERROR:
      begin
        if (!rx_evt.carrier_valid)
        begin
          car_state_nxt = CAR_IDLE;
          rx_err_inc    = 1'b1;
        end
        else if (rx_evt.collision)
          car_state_nxt = CAR_VETO;
        else
          car_state_nxt = CAR_ERROR;
      end
      CAR_VETO:
      begin
        if (!rx_evt.carrier_valid)
          car_state_nxt = CAR_IDLE;
        else
          car_state_nxt = CAR_VETO;
      end
      default:
      begin
        car_state_nxt = CAR_IDLE;
      end
    endcase
  end

  // Event tallies
  assign tally_inc[T_FC] = rx_evt.false_carrier;
  assign tally_inc[T_RE] = rx_err_inc;
  assign tally_clr[T_FC] = rd_fc;
  assign tally_clr[T_RE] = rd_re;

  generate
    for (genvar t = 0; t < N_TALLY; t++)
    begin : g_tally
      logic [CNT_W-1:0] cnt_r;

      always_ff @(posedge core_clk)
      begin
        if (!nrst)
          cnt_r <= '0;
        else
          cnt_r <= tally_next(cnt_r, tally_inc[t], tally_clr[t]);
      end

      assign tally_q[t] = cnt_r;
    end
  endgenerate

  // Configuration flags; reserved bits are not stored at all
  assign cfg_rst = {`PHYEC_RST_TRUE_QUIET,
                    `PHYEC_RST_SD_OVERRIDE,
                    `PHYEC_RST_SD_ALGO,
                    `PHYEC_RST_DESC_EXTEND};

  generate
    for (genvar b = 0; b < N_CFG; b++)
    begin : g_cfg
      logic flag_r;

      always_ff @(posedge core_clk)
      begin
        if (!nrst)
          flag_r <= cfg_rst[b];
        else if (cfg_wr)
          flag_r <= reg_wdata[cfg_bit_pos(b)];
      end

      assign cfg_bits[b] = flag_r;
    end
  endgenerate

  // Read answer, one cycle after the strobe
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      reg_rvalid_r <= 1'b0;
    else
      reg_rvalid_r <= reg_rd;
  end

  // Unmapped reads and idle cycles give zero
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      reg_rdata_r <= 16'h0000;
    else if (rd_fc)
      reg_rdata_r <= pad_tally(tally_q[T_FC]);
    else if (rd_re)
      reg_rdata_r <= pad_tally(tally_q[T_RE]);
    else if (rd_cfg)
      reg_rdata_r <= cfg_word(cfg_bits);
    else
      reg_rdata_r <= 16'h0000;
  end

  assign reg_rdata  = reg_rdata_r;
  assign reg_rvalid = reg_rvalid_r;
  assign pcs_cfg    = phyec_cfg_t'(cfg_bits);

  // Timeout length handed to the descrambler; counted in core clocks,
  // so TMO_W must grow if the clock is ever raised

  assign desc_timeout_cycles = cfg_bits[0]
                             ? TMO_W'(DESC_EXT_CYC)
                             : TMO_W'(DESC_STD_CYC);

endmodule

/* verif/phyec_regs_sva.sv */
`timescale 1ns/100ps
module phyec_regs_sva
  import phyec_pkg::*;
(
  // Watched ports
  input wire logic      core_clk,
  input wire logic      nrst,
  input wire logic      reg_wr,
  input wire logic      reg_rd,
  input wire logic      reg_rvalid,
  input wire logic[4:0] reg_addr,
  input wire logic[15:0] reg_wdata,
  input wire logic[15:0] reg_rdata,
  input phyec_rx_evt_t  rx_evt,
  input phyec_cfg_t     pcs_cfg
);
  wire fc = rx_evt.false_carrier;
  wire cw = reg_wr && reg_addr == 5'h16;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_rd(a, e);
    reg_rd && reg_addr == a && fc == e;
  endsequence
  rsv_zero_a:
    assert property (reg_rvalid |-> reg_rdata[15:11] == 5'h0) else $error("rsv");
  cfg_read_a:
    assert property (reg_rd && reg_addr == 5'h16 && !reg_wr
      |=> reg_rdata == {5'h0, $past(pcs_cfg), 7'h0}) else $error("cfg rd");
  cfg_write_a:
    assert property (cw |=> pcs_cfg == $past(reg_wdata[10:7])) else $error("cfg wr");
  cfg_hold_a:
    assert property (!cw |=> $stable(pcs_cfg)) else $error("cfg moved");
  rd_ans_a:
    assert property (reg_rd |=> reg_rvalid) else $error("no rvalid");
  rd_quiet_a:
    assert property (!reg_rd |=> !reg_rvalid) else $error("rvalid");
  clr_rd_a:
    assert property (s_rd(5'h14, 0) ##1 !fc ##1 s_rd(5'h14, 0) |=> reg_rdata == 16'h0)
      else $error("no clear");
  set_win_a:
    assert property (s_rd(5'h14, 1) ##1 !fc ##1 s_rd(5'h14, 0) |=> reg_rdata == 16'h1)
      else $error("lost");
endmodule
bind phyec_regs phyec_regs_sva u_sva (.core_clk, .nrst, .reg_wr, .reg_rd, .reg_rvalid,
  .reg_addr, .reg_wdata, .reg_rdata, .rx_evt, .pcs_cfg);

/* verif/phyec_mgmt_model.sv */
`timescale 1ns/100ps
module phyec_mgmt_model (
  // Station side
  input wire logic       core_clk,
  input wire logic[15:0] reg_rdata,
  output logic[4:0]      reg_addr,
  output logic           reg_wr,
  output logic           reg_rd,
  output logic[15:0]     reg_wdata
);
  initial {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
  // Released lines invert so stale values never pass
  task automatic wr(logic [4:0] a, logic [15:0] v);
    #1 {reg_addr, reg_wr, reg_wdata} = {a, 1'b1, v & 16'he7ff};
    @(posedge core_clk) #1 {reg_addr, reg_wr, reg_wdata} = {~a, 1'b0, ~v};
  endtask
  task automatic rd(logic [4:0] a, output logic [15:0] v);
    #1 {reg_addr, reg_rd} = {a, 1'b1};
    @(posedge core_clk) #1 {reg_addr, reg_rd} = {~a, 1'b0};
    // Answer stands for the cycle after the read edge; take it 1 ns after that edge
    v = reg_rdata;
    @(posedge core_clk);
  endtask
endmodule

/* verif/phyec_regs_bench.sv */
`timescale 1ns/100ps
module phyec_regs_bench
  import phyec_pkg::*;
;
  logic core_clk = 0, nrst = 0, reg_wr, reg_rd, reg_rvalid;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [16:0] desc_timeout_cycles;
  logic [31:0] s = 32'hd7a08e94;
  phyec_rx_evt_t rx_evt = '0;
  phyec_cfg_t pcs_cfg;
  int error_cnt = 0, samples_checked = 0, cyc = 0, n;
  initial forever #10 core_clk = ~core_clk;
  phyec_regs #(.DESC_STD_CYC(10), .DESC_EXT_CYC(30)) i_phyec_regs (.core_clk, .nrst,
    .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .rx_evt, .pcs_cfg,
    .desc_timeout_cycles);
  phyec_mgmt_model m (.core_clk, .reg_rdata, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  function automatic logic [15:0] cfg_exp(logic [15:0] w);
    return {5'h0, w[10:7], 7'h0};
  endfunction
  task automatic chk(string nm, logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("mismatches %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Bits: carrier, invalid symbol, collision
  task automatic carrier(int k, logic col);
    @(posedge core_clk) #1 rx_evt[2] = 1;
    repeat (k) @(posedge core_clk) #1 rx_evt[1:0] = {1'b1, col};
    @(posedge core_clk) #1 rx_evt = '0;
    @(posedge core_clk);
  endtask
  always @(posedge core_clk)
    if (++cyc == 5000)
    begin
      error_cnt++;
      print_verdict();
    end
  initial
  begin
    repeat (2) @(posedge core_clk);
    #1 nrst = 1;
    m.rd(5'h16, d);
    chk("reset cfg", d, cfg_exp(16'h0100));
    for (int a = 20; a < 24; a++)
    begin
      m.wr(5'(a), 16'hffff);
      m.rd(5'(a), d);
      chk("masked", d, a == 22 ? cfg_exp(16'hffff) : 16'h0);
    end
    repeat (6)
    begin
      s = xs(s);
      m.wr(5'h16, s[15:0]);
      m.rd(5'h16, d);
      chk("cfg", d, cfg_exp(s[15:0]));
      chk("tmo", 16'(desc_timeout_cycles), s[7] ? 16'd30 : 16'd10);
    end
    for (int i = 0; i < 4; i++)
    begin
      s = xs(s);
      n = i == 3 ? 300 : 1 + s[4:0];
      repeat (n) @(posedge core_clk) #1 rx_evt.false_carrier = 1;
      @(posedge core_clk) #1 rx_evt.false_carrier = 0;
      m.rd(5'h14, d);
      chk("fc", d, n > 255 ? 16'h00ff : 16'(n));
      m.rd(5'h14, d);
    end
    fork
      m.rd(5'h14, d);
      #1 rx_evt.false_carrier = 1;
      @(posedge core_clk) #1 rx_evt.false_carrier = 0;
    join
    m.rd(5'h14, d);
    chk("fc kept", d, 16'h1);
    carrier(3, 1'b0);
    carrier(2, 1'b1);
    m.rd(5'h15, d);
    chk("rx err", d, 16'h1);
    repeat (260) carrier(1, 1'b0);
    m.rd(5'h15, d);
    chk("rx sat", d, 16'h00ff);
    print_verdict();
  end
endmodule
